// >>> pkg/acv_defines.svh
// Offsets, reset values and timing counts of the converter control block.
`ifndef ACV_DEFINES_SVH
`define ACV_DEFINES_SVH

// =============================================================
// Register offsets
`define ACV_OFS_SC1   4'h0
`define ACV_OFS_SC2   4'h1
`define ACV_OFS_CFG   4'h2
`define ACV_OFS_RH    4'h3
`define ACV_OFS_RL    4'h4
`define ACV_OFS_CVH   4'h5
`define ACV_OFS_CVL   4'h6
`define ACV_OFS_PCTL1 4'h7
`define ACV_OFS_PCTL2 4'h8

// =============================================================
// Reset values
`define ACV_RST_SC1   8'h1F
`define ACV_RST_ZERO  8'h00
`define ACV_CH_IDLE   5'h1F

// =============================================================
// Field codes and conversion lengths in conversion clock cycles
`define ACV_CLK_BUS   2'h0
`define ACV_CLK_HALF  2'h1
`define ACV_CLK_ALT   2'h2
`define ACV_CLK_ASYNC 2'h3
`define ACV_MODE_10   2'h2
`define ACV_LEN_8     8'h14
`define ACV_LEN_10    8'h17
`define ACV_LEN_LONG  8'h14

`endif

// >>> pkg/acv_pkg.sv
// Types shared by the converter control block.
package acv_pkg;

    // Configuration register image.
    typedef struct packed {
        logic       low_power_config;
        logic [1:0] clock_divide_select;
        logic       long_sample_select;
        logic [1:0] resolution_select;
        logic [1:0] input_clock_select;
    } acv_cfg_t;

    // Status/control one image.
    typedef struct packed {
        logic       conv_complete_flag;
        logic       conv_irq_enable;
        logic       continuous_conv_enable;
        logic [4:0] input_channel_select;
    } acv_sc1_t;

    // Writable part of status/control two.
    typedef struct packed {
        logic trigger_source_select;
        logic compare_enable;
        logic compare_greater_select;
    } acv_sc2_t;

    typedef enum logic {ACV_IDLE, ACV_CONV} acv_state_t;

endpackage

// >>> core/acv_clk_div.sv
// Conversion clock divider producing a one-cycle enable pulse.
`timescale 1ns/1ps
module acv_clk_div #(
    parameter int CW = 3
) (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       arst_n_i,
    // Control
    input  wire logic       clear_i,
    input  wire logic       src_tick_i,
    input  wire logic [1:0] div_sel_i,
    // Output
    output logic            tick_o
);
    logic [CW-1:0] cnt;
    logic [CW-1:0] top;

    assign top = CW'((4'h1 << div_sel_i) - 4'h1);

    // =============================================================
    // Divide by 1, 2, 4 or 8
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt    <= '0;
            tick_o <= 1'b0;
        end else if (clear_i) begin
            cnt    <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= src_tick_i && (cnt == top);
            if (src_tick_i) begin
                cnt <= (cnt == top) ? '0 : CW'(cnt + 1'b1);
            end
        end
    end

    property p_div_one;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (!clear_i && src_tick_i && div_sel_i == 2'h0) |=> tick_o;
    endproperty
    a_div_one : assert property (p_div_one) else $error("divide by one lost a tick");

endmodule // acv_clk_div

// >>> core/acv_ctrl.sv
// Converter control: registers, conversion sequencing and low-power behaviour.
`timescale 1ns/1ps
`include "acv_defines.svh"
module acv_ctrl
    import acv_pkg::*;
#(
    parameter int RES_W = 10
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             arst_n_i,
    // Register port
    input  wire logic [3:0]       addr_i,
    input  wire logic [7:0]       wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [7:0]       rdata_o,
    // Power mode requests
    input  wire logic             wait_i,
    input  wire logic             stop3_i,
    input  wire logic             stop12_i,
    // Clock enables and trigger
    input  wire logic             alt_tick_i,
    input  wire logic             async_tick_i,
    input  wire logic             hw_trig_i,
    // Analog front end
    input  wire logic [RES_W-1:0] sample_i,
    output logic      [4:0]       channel_o,
    output logic                  low_power_o,
    output logic                  async_gen_o,
    output logic      [15:0]      pin_ctl_o,
    // Status
    output logic                  irq_o
);
    acv_cfg_t         cfg;
    acv_sc1_t         sc1;
    acv_sc2_t         sc2;
    acv_state_t       state;
    logic [7:0]       cnt;
    logic [RES_W-1:0] cval;
    logic [RES_W-1:0] result;
    logic [15:0]      pctl;
    logic             block;
    logic             half;
    logic             stop3_q;

    logic             soft_rst;
    logic             is_async;
    logic             run_ok;
    logic             stop3_abort;
    logic             src_tick;
    logic             conv_tick;
    logic             wr_sc1;
    logic             cfg_wr;
    logic             abort;
    logic             sw_start;
    logic             hw_start;
    logic             done;
    logic             cmp_true;
    logic             transfer;
    logic             restart;
    logic             start;
    logic [7:0]       total;
    logic [RES_W-1:0] sample_m;
    logic [RES_W-1:0] xfer_val;
    logic [7:0]       next_rdata;

    // =============================================================
    // Power modes and clock source
    // stop1/2 reset.
    assign soft_rst    = stop12_i;
    assign is_async    = (cfg.input_clock_select == `ACV_CLK_ASYNC);
    assign run_ok      = wait_i || !stop3_i || is_async;
    assign stop3_abort = stop3_i && !stop3_q && !is_async;

    always_comb begin
        unique case (cfg.input_clock_select)
            `ACV_CLK_BUS:  src_tick = 1'b1;
            `ACV_CLK_HALF: src_tick = half;
            `ACV_CLK_ALT:  src_tick = alt_tick_i;
            `ACV_CLK_ASYNC: src_tick = async_tick_i;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            half    <= 1'b0;
            stop3_q <= 1'b0;
        end else begin
            half    <= !half;
            stop3_q <= stop3_i;
        end
    end

    // The divider is cleared at every start so each conversion begins phase aligned.
    acv_clk_div #(
        .CW(3)
    ) u_div (
        .core_clk_i(core_clk_i),
        .arst_n_i  (arst_n_i),
        .clear_i   (soft_rst || start),
        .src_tick_i(src_tick && run_ok),
        .div_sel_i (cfg.clock_divide_select),
        .tick_o    (conv_tick)
    );

    // =============================================================
    // Conversion sequencing
    assign wr_sc1   = wr_i && (addr_i == `ACV_OFS_SC1);
    assign cfg_wr   = wr_i && (addr_i == `ACV_OFS_SC2 || addr_i == `ACV_OFS_CFG ||
                               addr_i == `ACV_OFS_CVH || addr_i == `ACV_OFS_CVL);
    assign abort    = wr_sc1 || cfg_wr || stop3_abort;
    assign sw_start = wr_sc1 && (wdata_i[4:0] != `ACV_CH_IDLE) && !sc2.trigger_source_select;
    assign hw_start = hw_trig_i && sc2.trigger_source_select && state == ACV_IDLE;
    assign done     = (state == ACV_CONV) && conv_tick && (cnt == 8'h01);
    assign total    = ((cfg.resolution_select == `ACV_MODE_10) ? `ACV_LEN_10 : `ACV_LEN_8) +
                      (cfg.long_sample_select ? `ACV_LEN_LONG : 8'h00);
    assign sample_m = (cfg.resolution_select == `ACV_MODE_10) ? sample_i :
                      {{(RES_W-8){1'b0}}, sample_i[7:0]};

    always_comb begin
        if (!sc2.compare_enable) begin
            cmp_true = 1'b1;
        end else if (sc2.compare_greater_select) begin
            cmp_true = (sample_m >= cval);
        end else begin
            cmp_true = (sample_m < cval);
        end
    end

    assign transfer = done && cmp_true && !block;
    assign restart  = done && (sc1.continuous_conv_enable || (block && cmp_true));
    assign start    = run_ok && !stop3_abort && (sw_start || hw_start || restart);
    assign xfer_val = sc2.compare_enable ? RES_W'(sample_m - cval) : sample_m;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ACV_IDLE;
            cnt   <= 8'h00;
        end else if (soft_rst) begin
            state <= ACV_IDLE;
            cnt   <= 8'h00;
        end else if (start) begin
            state <= ACV_CONV;
            cnt   <= total;
        end else if (abort || done) begin
            state <= ACV_IDLE;
            cnt   <= 8'h00;
        end else if (state == ACV_CONV && conv_tick) begin
            cnt <= cnt - 8'h01;
        end
    end

    // =============================================================
    // Result and blocking
    // results kept.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result <= '0;
        end else if (soft_rst) begin
            result <= '0;
        end else if (transfer) begin
            result <= xfer_val;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            block <= 1'b0;
        end else if (soft_rst) begin
            block <= 1'b0;
        end else if (rd_i && addr_i == `ACV_OFS_RL) begin
            block <= 1'b0;
        end else if (rd_i && addr_i == `ACV_OFS_RH && cfg.resolution_select == `ACV_MODE_10) begin
            block <= 1'b1;
        end
    end

    // =============================================================
    // Registers
    // configuration layout.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg <= `ACV_RST_ZERO;
        end else if (soft_rst) begin
            cfg <= `ACV_RST_ZERO;
        end else if (wr_i && addr_i == `ACV_OFS_CFG) begin
            cfg <= wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sc2 <= '0;
        end else if (soft_rst) begin
            sc2 <= '0;
        end else if (wr_i && addr_i == `ACV_OFS_SC2) begin
            sc2 <= wdata_i[6:4];
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sc1 <= `ACV_RST_SC1;
        end else if (soft_rst) begin
            sc1 <= `ACV_RST_SC1;
        end else begin
            if (wr_sc1) begin
                sc1.conv_irq_enable        <= wdata_i[6];
                sc1.continuous_conv_enable <= wdata_i[5];
                sc1.input_channel_select   <= wdata_i[4:0];
            end
            if (transfer) begin
                sc1.conv_complete_flag <= 1'b1;
            end else if (wr_sc1 || (rd_i && addr_i == `ACV_OFS_RL)) begin
                sc1.conv_complete_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cval <= '0;
        end else if (soft_rst) begin
            cval <= '0;
        end else if (wr_i && addr_i == `ACV_OFS_CVH) begin
            cval[RES_W-1:8] <= wdata_i[RES_W-9:0];
        end else if (wr_i && addr_i == `ACV_OFS_CVL) begin
            cval[7:0] <= wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pctl <= 16'h0000;
        end else if (soft_rst) begin
            pctl <= 16'h0000;
        end else if (wr_i && addr_i == `ACV_OFS_PCTL1) begin
            pctl[7:0] <= wdata_i;
        end else if (wr_i && addr_i == `ACV_OFS_PCTL2) begin
            pctl[15:8] <= wdata_i;
        end
    end

    // =============================================================
    // Read port
    // control two readback.
    always_comb begin
        next_rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `ACV_OFS_SC1:   next_rdata = sc1;
                `ACV_OFS_SC2:   next_rdata = {state == ACV_CONV, sc2, 4'h0};
                `ACV_OFS_CFG:   next_rdata = cfg;
                `ACV_OFS_RH:    next_rdata = 8'(result[RES_W-1:8]);
                `ACV_OFS_RL:    next_rdata = result[7:0];
                `ACV_OFS_CVH:   next_rdata = 8'(cval[RES_W-1:8]);
                `ACV_OFS_CVL:   next_rdata = cval[7:0];
                `ACV_OFS_PCTL1: next_rdata = pctl[7:0];
                `ACV_OFS_PCTL2: next_rdata = pctl[15:8];
                default:        next_rdata = 8'h00;
            endcase
        end
    end

    // =============================================================
    // Outputs
    // wake interrupt.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o     <= 8'h00;
            irq_o       <= 1'b0;
            channel_o   <= `ACV_CH_IDLE;
            low_power_o <= 1'b0;
            async_gen_o <= 1'b0;
            pin_ctl_o   <= 16'h0000;
        end else begin
            rdata_o     <= next_rdata;
            irq_o       <= sc1.conv_complete_flag && sc1.conv_irq_enable;
            channel_o   <= sc1.input_channel_select;
            low_power_o <= cfg.low_power_config;
            async_gen_o <= is_async && state == ACV_CONV;
            pin_ctl_o   <= pctl;
        end
    end

    // =============================================================
    // Checks
    property p_stop3_abort;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        stop3_abort && !soft_rst |=> state == ACV_IDLE;
    endproperty
    a_stop3_abort : assert property (p_stop3_abort) else $error("stop3 did not abort");

    property p_stop3_keep;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        $rose(stop3_i) && !stop12_i |=> $stable(result);
    endproperty
    a_stop3_keep : assert property (p_stop3_keep) else $error("result changed at stop3");

    property p_stop3_idle;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        stop3_i && !is_async && !wait_i && state == ACV_IDLE |=> state == ACV_IDLE;
    endproperty
    a_stop3_idle : assert property (p_stop3_idle) else $error("start during stop3");

    property p_stop3_run;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        $rose(stop3_i) && is_async && state == ACV_CONV && !done && !abort && !soft_rst
            |=> state == ACV_CONV;
    endproperty
    a_stop3_run : assert property (p_stop3_run) else $error("async conversion stopped");

    property p_stop12;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        stop12_i |=> cfg == `ACV_RST_ZERO && sc1 == `ACV_RST_SC1 && state == ACV_IDLE;
    endproperty
    a_stop12 : assert property (p_stop12) else $error("stop1/2 left state");

    property p_irq;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        transfer && sc1.conv_irq_enable && !soft_rst && !wr_sc1 |=> sc1.conv_complete_flag ##1 irq_o;
    endproperty
    a_irq : assert property (p_irq) else $error("no interrupt after completion");

    property p_block;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        done && block && !soft_rst |=> $stable(result);
    endproperty
    a_block : assert property (p_block) else $error("blocked result transferred");

    property p_sw_start;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        sw_start && run_ok && !stop3_abort && !soft_rst |=> state == ACV_CONV && cnt == $past(total);
    endproperty
    a_sw_start : assert property (p_sw_start) else $error("write did not restart");

    property p_sc2_zero;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        rd_i && addr_i == `ACV_OFS_SC2 |=> rdata_o[3:0] == 4'h0;
    endproperty
    a_sc2_zero : assert property (p_sc2_zero) else $error("reserved bits nonzero");

endmodule // acv_ctrl

// >>> verif/acv_ctrl_tb_top.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
`include "acv_defines.svh"
module acv_ctrl_tb_top;

    // =============================================================
    // Stimulus and observed signals
    logic        core_clk_i;
    logic        arst_n_i;
    logic [3:0]  addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  rdata_o;
    logic        wait_i;
    logic        stop3_i;
    logic        stop12_i;
    logic        alt_tick_i;
    logic        async_tick_i;
    logic        hw_trig_i;
    logic [9:0]  sample_i;
    logic [4:0]  channel_o;
    logic        low_power_o;
    logic        async_gen_o;
    logic [15:0] pin_ctl_o;
    logic        irq_o;
    logic [7:0]  rv;
    int          num_errors;
    int          n_checks;
    // Rows: address, write data, expected read back.
    logic [19:0] rows [4] = '{{4'h2, 8'h98, 8'h98}, {4'h1, 8'h7C, 8'h70},
                              {4'h0, 8'h1F, 8'h1F}, {4'hF, 8'hAA, 8'h00}};

    acv_ctrl #(.RES_W(10)) uut (
        .core_clk_i  (core_clk_i),
        .arst_n_i    (arst_n_i),
        .addr_i      (addr_i),
        .wdata_i     (wdata_i),
        .wr_i        (wr_i),
        .rd_i        (rd_i),
        .rdata_o     (rdata_o),
        .wait_i      (wait_i),
        .stop3_i     (stop3_i),
        .stop12_i    (stop12_i),
        .alt_tick_i  (alt_tick_i),
        .async_tick_i(async_tick_i),
        .hw_trig_i   (hw_trig_i),
        .sample_i    (sample_i),
        .channel_o   (channel_o),
        .low_power_o (low_power_o),
        .async_gen_o (async_gen_o),
        .pin_ctl_o   (pin_ctl_o),
        .irq_o       (irq_o)
    );

    // =============================================================
    // Clock, slow clock enables and watchdog
    always #5 core_clk_i = ~core_clk_i;

    // The alternate and async enables tick every other cycle, slower than the bus.
    always @(posedge core_clk_i) begin
        async_tick_i <= ~async_tick_i;
        alt_tick_i   <= ~alt_tick_i;
    end

    initial begin
        #100us;
        num_errors++;
        close_out();
    end

    // =============================================================
    // Shared tasks
    task automatic close_out();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [16:0] s, input logic [16:0] e);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge core_clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge core_clk_i);
        rd_i   <= 1'b0;
        #1;
        rv = rdata_o;
    endtask

    // High byte first, which also exercises the result blocking path.
    task automatic rres(input logic [9:0] e);
        rd(`ACV_OFS_RH);
        chk(rv, {6'h00, e[9:8]});
        rd(`ACV_OFS_RL);
        chk(rv, e[7:0]);
    endtask

    task automatic wirq();
        int i;
        i = 0;
        // A flag cleared by the last read still shows on the registered irq for one cycle.
        @(posedge core_clk_i);
        #1;
        while (irq_o !== 1'b1 && i < 300) begin
            @(posedge core_clk_i);
            i++;
        end
        #1;
        chk(irq_o, 1'b1);
    endtask

    task automatic quiet(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
        chk(irq_o, 1'b0);
    endtask

    // =============================================================
    // Main sequence
    initial begin
        {core_clk_i, arst_n_i, addr_i, wdata_i, wr_i, rd_i} = '0;
        {wait_i, stop3_i, stop12_i, alt_tick_i, async_tick_i, hw_trig_i} = '0;
        sample_i   = 10'h2A5;
        num_errors = 0;
        n_checks   = 0;
        repeat (12) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        foreach (rows[k]) begin
            wr(rows[k][19:16], rows[k][15:8]);
            rd(rows[k][19:16]);
            chk(rv, rows[k][7:0]);
        end
        // Plain software conversion, 10-bit, bus clock.
        wr(`ACV_OFS_CFG, 8'h08);
        wr(`ACV_OFS_SC2, 8'h00);
        wr(`ACV_OFS_SC1, 8'h41);
        @(posedge core_clk_i);
        #1;
        chk(channel_o, 5'h01);
        rd(`ACV_OFS_SC2);
        chk(rv, 8'h80);
        wirq();
        rd(`ACV_OFS_SC1);
        chk(rv, 8'hC1);
        rres(10'h2A5);
        quiet(2);
        // Conversion running when wait is entered.
        wr(`ACV_OFS_SC1, 8'h41);
        repeat (5) @(posedge core_clk_i);
        wait_i <= 1'b1;
        wirq();
        rres(10'h2A5);
        // Hardware trigger in wait; the register write alone must not start.
        wr(`ACV_OFS_SC2, 8'h40);
        wr(`ACV_OFS_SC1, 8'h41);
        quiet(40);
        @(posedge core_clk_i);
        hw_trig_i <= 1'b1;
        @(posedge core_clk_i);
        hw_trig_i <= 1'b0;
        wirq();
        rres(10'h2A5);
        wait_i <= 1'b0;
        wr(`ACV_OFS_SC2, 8'h00);
        // Stop3 on the bus clock aborts and leaves the results alone.
        sample_i <= 10'h155;
        wr(`ACV_OFS_SC1, 8'h41);
        repeat (5) @(posedge core_clk_i);
        stop3_i <= 1'b1;
        quiet(40);
        rd(`ACV_OFS_SC2);
        chk(rv, 8'h00);
        rres(10'h2A5);
        stop3_i <= 1'b0;
        quiet(40);
        // Async clock keeps converting through stop3.
        // Blocking was cleared by the last low byte read before stop3.
        wr(`ACV_OFS_CFG, 8'h0B);
        wr(`ACV_OFS_SC1, 8'h41);
        repeat (5) @(posedge core_clk_i);
        stop3_i <= 1'b1;
        #1;
        chk(async_gen_o, 1'b1);
        wirq();
        rres(10'h155);
        stop3_i <= 1'b0;
        // Continuous mode, high byte read holds off the next result.
        wr(`ACV_OFS_CFG, 8'h08);
        sample_i <= 10'h1F0;
        wr(`ACV_OFS_SC1, 8'h61);
        wirq();
        rd(`ACV_OFS_RH);
        chk(rv, 8'h01);
        sample_i <= 10'h3C3;
        repeat (80) @(posedge core_clk_i);
        rd(`ACV_OFS_RL);
        chk(rv, 8'hF0);
        wirq();
        rres(10'h3C3);
        wr(`ACV_OFS_SC1, 8'h1F);
        // Compare function: false condition gives nothing, true gives the difference.
        sample_i <= 10'h2A5;
        wr(`ACV_OFS_CVH, 8'h01);
        wr(`ACV_OFS_CVL, 8'h00);
        wr(`ACV_OFS_SC2, 8'h20);
        wr(`ACV_OFS_SC1, 8'h41);
        quiet(80);
        wr(`ACV_OFS_SC2, 8'h30);
        wr(`ACV_OFS_SC1, 8'h41);
        wirq();
        rres(10'h1A5);
        // Low power, pin control, then stop1/stop2 clears every mapped register and the conversion.
        wr(`ACV_OFS_CFG, 8'h98);
        wr(`ACV_OFS_PCTL1, 8'h02);
        @(posedge core_clk_i);
        #1;
        chk(low_power_o, 1'b1);
        chk(pin_ctl_o, 16'h0002);
        wr(`ACV_OFS_SC1, 8'h41);
        stop12_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        stop12_i <= 1'b0;
        rd(`ACV_OFS_CFG);
        chk(rv, 8'h00);
        rd(`ACV_OFS_SC1);
        chk(rv, 8'h1F);
        chk({low_power_o, pin_ctl_o}, 17'h0);
        quiet(60);
        // Mid-run reset returns the documented reset values.
        wr(`ACV_OFS_SC1, 8'h41);
        arst_n_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        #1;
        chk(channel_o, 5'h1F);
        rd(`ACV_OFS_RL);
        chk(rv, 8'h00);
        close_out();
    end

endmodule // acv_ctrl_tb_top
